// ===== verif/pad_side_model.sv
// Pad-side model: external pin levels and peripheral function selects.
// Assumes the bench sets target levels; pads follow with a skew to the clock.
`timescale 1ns/1ps
`default_nettype none

module pad_side_model (
   input  wire logic        ref_clk_in,
   input  wire logic [31:0] level_in,
   input  wire logic [31:0] two_wire_in,
   output var  logic [31:0] pin_out,
   output var  logic [31:0] two_wire_sel_out
);
   // Pins move off the clock grid so nothing lines up with an edge.
   assign #1.3 pin_out = level_in;
   always @(posedge ref_clk_in) two_wire_sel_out <= two_wire_in;
endmodule
`default_nettype wire

// ===== verif/port_pin_control_props.sv
// Concurrent checks on the ports of the pin control block.
// Assumes one clock domain with an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module port_pin_control_props #(
   parameter port_ctl_pkg::port_id_type port_id = port_ctl_pkg::port_a,
   parameter logic [31:0] low_power_timer_alt_inputs = 32'h00000000
) (
   input wire logic        ref_clk_in,
   input wire logic        sys_rst_in,
   input wire logic [7:0]  addr_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [31:0] two_wire_sel_in,
   input wire logic        wait_mode_in,
   input wire logic        stop_mode_in,
   input wire logic [31:0] rdata_out,
   input wire logic        bus_err_out,
   input wire logic [31:0] pull_enable_out,
   input wire logic [31:0] pull_select_out,
   input wire logic [31:0] filter_enable_out,
   input wire logic [31:0] drive_high_out,
   input wire logic [31:0] open_drain_out,
   input wire logic        irq_out,
   input wire logic        wake_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);

   property p_rdata_idle;
      !$past(rd_in) |-> rdata_out == 32'h00000000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");

   property p_err_misaligned;
      (rd_in || wr_in) && addr_in[1:0] != 2'h0 |=> bus_err_out;
   endproperty
   a_err_misaligned: assert property (p_err_misaligned) else $error("no bus error");

   property p_err_mapped;
      (rd_in || wr_in) && addr_in[1:0] == 2'h0 && addr_in <= 8'h84 |=> !bus_err_out;
   endproperty
   a_err_mapped: assert property (p_err_mapped) else $error("bus error on mapped word");

   property p_err_cause;
      bus_err_out |-> $past(rd_in || wr_in);
   endproperty
   a_err_cause: assert property (p_err_cause) else $error("bus error without access");

   property p_open_drain;
      !$past(sys_rst_in) |-> open_drain_out == $past(two_wire_sel_in);
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("open drain mismatch");

   property p_reset_pin;
      port_id != port_ctl_pkg::port_a || (pull_enable_out[20] && pull_select_out[20]);
   endproperty
   a_reset_pin: assert property (p_reset_pin) else $error("reset pin pull not up");

   property p_lpt_pull;
      (pull_enable_out & low_power_timer_alt_inputs) == 32'h00000000;
   endproperty
   a_lpt_pull: assert property (p_lpt_pull) else $error("timer input pulled");

   property p_filter;
      (filter_enable_out & ~port_ctl_pkg::filter_ctl_mask[port_id]) == 32'h00000000;
   endproperty
   a_filter: assert property (p_filter) else $error("filter on unsupported line");

   property p_drive;
      (drive_high_out & ~port_ctl_pkg::drive_ctl_mask[port_id]) == 32'h00000000;
   endproperty
   a_drive: assert property (p_drive) else $error("drive on unsupported line");

   property p_wait_wake;
      wait_mode_in && irq_out && !stop_mode_in |=> wake_out;
   endproperty
   a_wait_wake: assert property (p_wait_wake) else $error("no wake in wait");

   property p_no_wake;
      !stop_mode_in && !(wait_mode_in && irq_out) |=> !wake_out;
   endproperty
   a_no_wake: assert property (p_no_wake) else $error("wake without cause");
endmodule
`default_nettype wire

// ===== verif/port_pin_control_tb.sv
// Self-checking bench for the pin control block on port A.
// Assumes the pad model and the bound checker compiled before it.
`timescale 1ns/1ps
`default_nettype none

module port_pin_control_tb;
   localparam logic [31:0] lpt_mask = 32'h00000004;
   logic        ref_clk_in, sys_rst_in, wr_in, rd_in, clk_run, err_seen, start, lvl;
   logic        wait_mode_in, stop_mode_in, irq_out, dma_req_out, wake_out, bus_err_out;
   logic [7:0]  addr_in;
   logic [31:0] wdata_in, rdata_out, level, two_wire, pins, sel, rd_word, w;
   logic [31:0] pull_enable_out, pull_select_out, slew_slow_out, filter_enable_out;
   logic [31:0] drive_high_out, open_drain_out;
   logic [95:0] mux_sel_out;
   logic [7:0]  bad [5] = '{8'h02, 8'h88, 8'h9c, 8'ha4, 8'hfd};
   logic [3:0]  cfgs [8] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
   int          n_errors, tests_run, n, k;

   pad_side_model u_pads (.ref_clk_in(ref_clk_in), .level_in(level), .two_wire_in(two_wire),
      .pin_out(pins), .two_wire_sel_out(sel));

   port_pin_control #(.low_power_timer_alt_inputs(lpt_mask)) u_dut (
      .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .port_pin_lines_in(pins),
      .two_wire_sel_in(sel), .wait_mode_in(wait_mode_in), .stop_mode_in(stop_mode_in),
      .rdata_out(rdata_out), .bus_err_out(bus_err_out), .pull_enable_out(pull_enable_out),
      .pull_select_out(pull_select_out), .slew_slow_out(slew_slow_out),
      .filter_enable_out(filter_enable_out), .drive_high_out(drive_high_out),
      .open_drain_out(open_drain_out), .mux_sel_out(mux_sel_out), .irq_out(irq_out),
      .dma_req_out(dma_req_out), .wake_out(wake_out));

   initial begin
      ref_clk_in = 1'b0;
      forever begin
         #2;
         if (clk_run) ref_clk_in = ~ref_clk_in;
      end
   end

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      wr_in <= wr;
      rd_in <= ~wr;
      addr_in <= a;
      wdata_in <= d;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
      rd_in <= 1'b0;
      #1 rd_word = rdata_out;
      err_seen = bus_err_out;
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Control word that a port A line holds straight after reset.
   function automatic logic [31:0] rst_word(input int i);
      logic seven;
      seven = (i == 0 || i == 3 || i == 4);
      rst_word = {21'h0, {3{seven}}, 5'h0, i != 3, i != 0, seven || i == 20};
   endfunction

   // Pad outputs of one line as {mux, drive, filter, slew, select, enable}.
   function automatic logic [31:0] exp_pad(input int i, input logic [31:0] c);
      logic pe;
      logic ps;
      pe = (i == 20) | (c[0] & ~lpt_mask[i]);
      ps = (i == 20) | c[1];
      exp_pad = {24'h0, c[10:8], 1'b0, c[4] & (i == 4), c[2], ps, pe};
   endfunction

   function automatic logic [31:0] got_pad(input int i);
      got_pad = {24'h0, mux_sel_out[3*i+:3], drive_high_out[i], filter_enable_out[i],
         slew_slow_out[i], pull_select_out[i], pull_enable_out[i]};
   endfunction

   initial begin
      #40000;
      n_errors++;
      wrap_up();
   end

   initial begin
      clk_run = 1'b1;
      sys_rst_in = 1'b1;
      {wr_in, rd_in, wait_mode_in, stop_mode_in} = 4'h0;
      addr_in = 8'h00;
      {wdata_in, level, two_wire} = {32'h0, 32'h0, 32'h0};
      n_errors = 0;
      tests_run = 0;
      void'($urandom(97));
      repeat (5) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      for (int i = 0; i < 32; i++) begin
         chk_word(got_pad(i), exp_pad(i, rst_word(i)));
         bus(1'b0, 8'(4 * i), 32'h0);
         chk_word(rd_word, rst_word(i));
      end
      chk_word(open_drain_out | filter_enable_out | drive_high_out, 32'h0);
      $display("test reset_values done");
      repeat (24) begin
         n = $urandom_range(31);
         w = $urandom() & 32'h00000757;
         two_wire <= $urandom();
         bus(1'b1, 8'(4 * n), w);
         chk_word(got_pad(n), exp_pad(n, w));
         bus(1'b0, 8'(4 * n), 32'h0);
         chk_word(rd_word, w & ~32'h40 & ~(n == 4 ? 32'h0 : 32'h10));
         chk_word(open_drain_out, two_wire);
      end
      bus(1'b1, port_ctl_pkg::gpclr_offset, 32'h00120017);
      bus(1'b1, port_ctl_pkg::gpchr_offset, 32'h00010306);
      chk_word(got_pad(1), exp_pad(1, 32'h17));
      chk_word(got_pad(4), exp_pad(4, 32'h17));
      chk_word(got_pad(16), exp_pad(16, 32'h306));
      $display("test random_pad done");
      for (int i = 0; i < 5; i++) begin
         bus(i % 2 == 0, bad[i], 32'hffffffff);
         chk_bit(err_seen, 1'b1);
         chk_word(rd_word, 32'h0);
      end
      bus(1'b0, 8'h84, 32'h0);
      chk_bit(err_seen, 1'b0);
      chk_word(rd_word, 32'h0);
      $display("test bus_errors done");
      wait_mode_in <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         start = cfgs[i] inside {port_ctl_pkg::cfg_dma_fall, port_ctl_pkg::cfg_irq_fall,
            port_ctl_pkg::cfg_irq_low};
         lvl = cfgs[i] inside {port_ctl_pkg::cfg_irq_low, port_ctl_pkg::cfg_irq_high};
         level[5] <= start;
         repeat (6) @(posedge ref_clk_in);
         bus(1'b1, 8'h14, {12'h0, cfgs[i], 16'h0});
         bus(1'b1, 8'ha0, 32'hffffffff);
         chk_bit(irq_out | dma_req_out, 1'b0);
         level[5] <= ~start;
         k = 0;
         do begin
            @(posedge ref_clk_in);
            #1 k++;
         end while (!(irq_out | dma_req_out) && k < 10);
         chk_bit(k >= 3 && k < 10, 1'b1);
         chk_bit(irq_out, cfgs[i][3]);
         chk_bit(dma_req_out, ~cfgs[i][3]);
         bus(1'b0, 8'ha0, 32'h0);
         chk_word(rd_word, 32'h00000020);
         chk_bit(wake_out, cfgs[i][3]);
         bus(1'b1, 8'ha0, 32'h00000020);
         chk_bit(irq_out | dma_req_out, lvl);
         bus(1'b1, 8'h14, 32'h0);
         bus(1'b1, 8'ha0, 32'hffffffff);
         chk_bit(irq_out | dma_req_out, 1'b0);
      end
      $display("test pin_events done");
      wait_mode_in <= 1'b0;
      stop_mode_in <= 1'b1;
      level[5] <= 1'b0;
      bus(1'b1, 8'h14, {12'h0, port_ctl_pkg::cfg_irq_rise, 16'h0});
      repeat (4) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      clk_run = 1'b0;
      chk_bit(wake_out, 1'b0);
      #20 level[5] = 1'b1;
      #10 chk_bit(wake_out, 1'b1);
      clk_run = 1'b1;
      stop_mode_in <= 1'b0;
      repeat (8) @(posedge ref_clk_in);
      #1 chk_bit(irq_out, 1'b1);
      bus(1'b1, 8'h14, 32'h0);
      bus(1'b1, 8'ha0, 32'hffffffff);
      $display("test stop_wake done");
      wrap_up();
   end
endmodule

bind port_pin_control port_pin_control_props #(.port_id(port_id),
   .low_power_timer_alt_inputs(low_power_timer_alt_inputs)) u_props (
   .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wr_in(wr_in),
   .rd_in(rd_in), .two_wire_sel_in(two_wire_sel_in), .wait_mode_in(wait_mode_in),
   .stop_mode_in(stop_mode_in), .rdata_out(rdata_out), .bus_err_out(bus_err_out),
   .pull_enable_out(pull_enable_out), .pull_select_out(pull_select_out),
   .filter_enable_out(filter_enable_out), .drive_high_out(drive_high_out),
   .open_drain_out(open_drain_out), .irq_out(irq_out), .wake_out(wake_out));
`default_nettype wire

// ===== verilog/pin_sync2.sv
// Two-stage synchroniser, one per pin line.
// Assumes pins change with no relation to the clock.
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 (
   input  wire logic        ref_clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic [31:0] pin_in,
   output var  logic [31:0] sync_out
);

   typedef struct packed {
      logic [31:0] meta;
      logic [31:0] sync;
   } sync_state_type;

   sync_state_type state_q;
   sync_state_type state_d;

   always_comb begin
      state_d      = state_q;
      state_d.meta = pin_in;
      state_d.sync = state_q.meta;
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign sync_out = state_q.sync;

endmodule

`default_nettype wire

// ===== verilog/pin_wake.sv
// Wake-up request for low-power modes.
// Assumes the clock may stop in stop mode; raw pins are compared against the
// last synchronised levels so that a change is seen without any clock edge.
`timescale 1ns/1ps
`default_nettype none

module pin_wake (
   input  wire logic         ref_clk_in,
   input  wire logic         sys_rst_in,
   input  wire logic         stop_mode_in,
   input  wire logic         wait_wake_in,
   input  wire logic [31:0]  pin_raw_in,
   input  wire logic [31:0]  pin_ref_in,
   input  wire logic [127:0] irq_cfg_in,
   output var  logic         wake_out
);

   typedef struct packed {
      logic wake;
   } wake_state_type;

   wake_state_type state_q;
   wake_state_type state_d;
   logic [31:0]    hit;
   logic           async_evt;

   always_comb begin
      for (int i = 0; i < 32; i++) begin
         hit[i] = port_ctl_pkg::event_hit(irq_cfg_in[4*i +: 4], pin_raw_in[i],
                                          pin_ref_in[i], 1'b1);
      end
      async_evt = stop_mode_in & (|hit);
   end

   always_comb begin
      state_d      = state_q;
      state_d.wake = wait_wake_in;
   end

   // Stop-mode events set the flop without a clock edge.
   always_ff @(posedge ref_clk_in or posedge sys_rst_in or posedge async_evt) begin
      if (sys_rst_in) begin
         state_q <= '0;
      end else if (async_evt) begin
         state_q <= 1'b1;
      end else begin
         state_q <= state_d;
      end
   end

   assign wake_out = state_q.wake;

endmodule

`default_nettype wire

// ===== verilog/port_ctl_pkg.sv
// Constants, reset tables and the event decoder of the pin control block.
// Assumes one block per port, all on one system clock.

package port_ctl_pkg;

   typedef enum logic [2:0] {
      port_a = 3'h0,
      port_b = 3'h1,
      port_c = 3'h2,
      port_d = 3'h3,
      port_e = 3'h4
   } port_id_type;

   // *****************************************************************
   // Register offsets (byte addresses).
   // *****************************************************************
   localparam logic [7:0] pcr_last_offset = 8'h7c;
   localparam logic [7:0] gpclr_offset    = 8'h80;
   localparam logic [7:0] gpchr_offset    = 8'h84;
   localparam logic [7:0] isfr_offset     = 8'ha0;

   // *****************************************************************
   // Pin control word layout.
   // *****************************************************************
   localparam int pull_enable_field_bit = 0;
   localparam int pull_select_field_bit = 1;
   localparam int slew_slow_bit         = 2;
   localparam int filter_enable_bit     = 4;
   localparam int drive_high_bit        = 6;
   localparam int mux_lsb               = 8;
   localparam int irq_cfg_lsb           = 16;
   localparam int flag_bit              = 24;
   localparam int global_select_lsb     = 16;
   localparam int reset_pin_line        = 20;

   // *****************************************************************
   // Event configuration codes.
   // *****************************************************************
   localparam logic [3:0] cfg_off        = 4'h0;
   localparam logic [3:0] cfg_dma_rise   = 4'h1;
   localparam logic [3:0] cfg_dma_fall   = 4'h2;
   localparam logic [3:0] cfg_dma_either = 4'h3;
   localparam logic [3:0] cfg_irq_low    = 4'h8;
   localparam logic [3:0] cfg_irq_rise   = 4'h9;
   localparam logic [3:0] cfg_irq_fall   = 4'ha;
   localparam logic [3:0] cfg_irq_either = 4'hb;
   localparam logic [3:0] cfg_irq_high   = 4'hc;

   localparam logic [2:0] mux_alternative_zero  = 3'h0;
   localparam logic [2:0] mux_alternative_seven = 3'h7;

   // *****************************************************************
   // Reset tables and control masks, indexed by port.
   // *****************************************************************
   localparam logic [31:0] pull_select_rst [5] =
      '{32'hfffffffe, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff};
   localparam logic [31:0] pull_enable_rst [5] =
      '{32'h00100019, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};
   localparam logic [31:0] slew_fast_rst [5] =
      '{32'h00000008, 32'h00030003, 32'h000000f8, 32'h000000ff, 32'h000f0003};
   localparam logic [31:0] mux_seven_rst [5] =
      '{32'h00000019, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};
   localparam logic [31:0] filter_ctl_mask [5] =
      '{32'h00000010, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};
   localparam logic [31:0] drive_ctl_mask [5] =
      '{32'h00000000, 32'h00000003, 32'h00000018, 32'h000000c0, 32'h00000000};

   // Decodes one configured event from a current and a previous pin level.
   function automatic logic event_hit(input logic [3:0] cfg,
                                      input logic       cur,
                                      input logic       prev,
                                      input logic       want_irq);
      logic rise;
      logic fall;
      rise = cur & ~prev;
      fall = ~cur & prev;
      event_hit = 1'b0;
      case (cfg)
         cfg_dma_rise:   event_hit = ~want_irq & rise;
         cfg_dma_fall:   event_hit = ~want_irq & fall;
         cfg_dma_either: event_hit = ~want_irq & (rise | fall);
         cfg_irq_low:    event_hit = want_irq & ~cur;
         cfg_irq_rise:   event_hit = want_irq & rise;
         cfg_irq_fall:   event_hit = want_irq & fall;
         cfg_irq_either: event_hit = want_irq & (rise | fall);
         cfg_irq_high:   event_hit = want_irq & cur;
         default:        event_hit = 1'b0;
      endcase
   endfunction

endpackage

// ===== verilog/port_pin_control.sv
// Pin control and pin event block for one 32-line port.
// Assumes a single-cycle register port on the system clock and asynchronous pins.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module port_pin_control #(
   parameter port_ctl_pkg::port_id_type port_id = port_ctl_pkg::port_a,
   parameter logic [31:0] low_power_timer_alt_inputs = 32'h00000000
) (
   input  wire logic        ref_clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   input  wire logic [31:0] port_pin_lines_in,
   input  wire logic [31:0] two_wire_sel_in,
   input  wire logic        wait_mode_in,
   input  wire logic        stop_mode_in,
   output var  logic [31:0] rdata_out,
   output var  logic        bus_err_out,
   output var  logic [31:0] pull_enable_out,
   output var  logic [31:0] pull_select_out,
   output var  logic [31:0] slew_slow_out,
   output var  logic [31:0] filter_enable_out,
   output var  logic [31:0] drive_high_out,
   output var  logic [31:0] open_drain_out,
   output var  logic [95:0] mux_sel_out,
   output var  logic        irq_out,
   output var  logic        dma_req_out,
   output var  logic        wake_out
);

   localparam int pix = int'(port_id);

   // *****************************************************************
   // State.
   // *****************************************************************
   typedef struct packed {
      logic [31:0]       pe;
      logic [31:0]       ps;
      logic [31:0]       sre;
      logic [31:0]       pfe;
      logic [31:0]       dse;
      logic [31:0][2:0]  mux;
      logic [31:0][3:0]  cfg;
      logic [31:0]       flag;
      logic [31:0]       prev;
      logic [31:0]       pe_out;
      logic [31:0]       ps_out;
      logic [31:0]       od_out;
      logic [31:0]       rdata;
      logic              berr;
      logic              irq;
      logic              dma;
      logic              wait_wake;
   } port_state_type;

   localparam port_state_type reset_state = '{
      pe:        port_ctl_pkg::pull_enable_rst[pix],
      ps:        port_ctl_pkg::pull_select_rst[pix],
      sre:       ~port_ctl_pkg::slew_fast_rst[pix],
      pfe:       32'h00000000,
      dse:       32'h00000000,
      mux:       {32{3'h0}} | mux_reset(port_ctl_pkg::mux_seven_rst[pix]),
      cfg:       '0,
      flag:      32'h00000000,
      prev:      32'h00000000,
      pe_out:    port_ctl_pkg::pull_enable_rst[pix] & ~low_power_timer_alt_inputs,
      ps_out:    port_ctl_pkg::pull_select_rst[pix],
      od_out:    32'h00000000,
      rdata:     32'h00000000,
      berr:      1'b0,
      irq:       1'b0,
      dma:       1'b0,
      wait_wake: 1'b0
   };

   function automatic logic [95:0] mux_reset(input logic [31:0] seven);
      logic [31:0][2:0] m;
      for (int i = 0; i < 32; i++) begin
         m[i] = seven[i] ? port_ctl_pkg::mux_alternative_seven
                         : port_ctl_pkg::mux_alternative_zero;
      end
      mux_reset = m;
   endfunction

   port_state_type state_q;
   port_state_type state_d;
   logic [31:0]    pin_sync;

   // *****************************************************************
   // Pin synchroniser and wake-up.
   // *****************************************************************
   pin_sync2 u_sync (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .pin_in     (port_pin_lines_in),
      .sync_out   (pin_sync)
   );

   pin_wake u_wake (
      .ref_clk_in   (ref_clk_in),
      .sys_rst_in   (sys_rst_in),
      .stop_mode_in (stop_mode_in),
      .wait_wake_in (state_q.wait_wake),
      .pin_raw_in   (port_pin_lines_in),
      .pin_ref_in   (state_q.prev),
      .irq_cfg_in   (state_q.cfg),
      .wake_out     (wake_out)
   );

   // *****************************************************************
   // Next state. Wait and stop modes reach only the wake-up logic.
   // *****************************************************************
   always_comb begin
      logic        pcr_hit;
      logic        pcr_wr;
      logic [4:0]  idx;
      logic [31:0] line_wr;
      logic [31:0] clr;
      logic [31:0] irq_mask;
      logic [31:0] dma_mask;
      logic        hit;
      logic        valid;
      pcr_hit  = (addr_in <= port_ctl_pkg::pcr_last_offset) && (addr_in[1:0] == 2'h0);
      pcr_wr   = wr_in & pcr_hit;
      idx      = addr_in[6:2];
      line_wr  = '0;
      clr      = '0;
      irq_mask = '0;
      dma_mask = '0;
      hit      = 1'b0;
      valid    = 1'b0;
      state_d  = state_q;
      state_d.prev  = pin_sync;
      state_d.berr  = 1'b0;
      state_d.rdata = 32'h00000000;

      for (int i = 0; i < 32; i++) begin
         line_wr[i] = (pcr_wr && (idx == 5'(i)))
            | (wr_in && (addr_in == port_ctl_pkg::gpclr_offset) && (i < 16)
               && wdata_in[port_ctl_pkg::global_select_lsb + (i % 16)])
            | (wr_in && (addr_in == port_ctl_pkg::gpchr_offset) && (i >= 16)
               && wdata_in[port_ctl_pkg::global_select_lsb + (i % 16)]);
         clr[i] = (pcr_wr && (idx == 5'(i)) && wdata_in[port_ctl_pkg::flag_bit])
            | (wr_in && (addr_in == port_ctl_pkg::isfr_offset) && wdata_in[i]);

         if (line_wr[i]) begin
            state_d.pe[i]  = wdata_in[port_ctl_pkg::pull_enable_field_bit];
            state_d.ps[i]  = wdata_in[port_ctl_pkg::pull_select_field_bit];
            state_d.sre[i] = wdata_in[port_ctl_pkg::slew_slow_bit];
            state_d.mux[i] = wdata_in[port_ctl_pkg::mux_lsb +: 3];
            if (port_ctl_pkg::filter_ctl_mask[pix][i]) begin
               state_d.pfe[i] = wdata_in[port_ctl_pkg::filter_enable_bit];
            end
            if (port_ctl_pkg::drive_ctl_mask[pix][i]) begin
               state_d.dse[i] = wdata_in[port_ctl_pkg::drive_high_bit];
            end
         end
         if (pcr_wr && (idx == 5'(i))) begin
            state_d.cfg[i] = wdata_in[port_ctl_pkg::irq_cfg_lsb +: 4];
         end

         // Detection ignores the mux selection; a set beats a clear.
         hit = port_ctl_pkg::event_hit(state_q.cfg[i], pin_sync[i], state_q.prev[i], 1'b1)
             | port_ctl_pkg::event_hit(state_q.cfg[i], pin_sync[i], state_q.prev[i], 1'b0);
         state_d.flag[i] = hit | (state_q.flag[i] & ~clr[i]);

         irq_mask[i] = state_q.cfg[i][3];
         dma_mask[i] = ~state_q.cfg[i][3] && (state_q.cfg[i] != port_ctl_pkg::cfg_off);

         if ((port_id == port_ctl_pkg::port_a) && (i == port_ctl_pkg::reset_pin_line)) begin
            state_d.pe_out[i] = 1'b1;
            state_d.ps_out[i] = 1'b1;
         end else if (low_power_timer_alt_inputs[i]) begin
            state_d.pe_out[i] = 1'b0;
            state_d.ps_out[i] = state_d.ps[i];
         end else begin
            state_d.pe_out[i] = state_d.pe[i];
            state_d.ps_out[i] = state_d.ps[i];
         end
         state_d.od_out[i] = two_wire_sel_in[i];
      end

      state_d.irq       = |(state_d.flag & irq_mask);
      state_d.dma       = |(state_d.flag & dma_mask);
      state_d.wait_wake = wait_mode_in & state_d.irq;

      // Register port: read data stand one cycle after the strobe.
      valid = pcr_hit
         || (addr_in == port_ctl_pkg::gpclr_offset)
         || (addr_in == port_ctl_pkg::gpchr_offset)
         || (addr_in == port_ctl_pkg::isfr_offset);
      state_d.berr = (rd_in | wr_in) & ~valid;
      if (rd_in && pcr_hit) begin
         state_d.rdata[port_ctl_pkg::pull_enable_field_bit] = state_q.pe[idx];
         state_d.rdata[port_ctl_pkg::pull_select_field_bit] = state_q.ps[idx];
         state_d.rdata[port_ctl_pkg::slew_slow_bit]         = state_q.sre[idx];
         state_d.rdata[port_ctl_pkg::filter_enable_bit]     = state_q.pfe[idx];
         state_d.rdata[port_ctl_pkg::drive_high_bit]        = state_q.dse[idx];
         state_d.rdata[port_ctl_pkg::mux_lsb +: 3]          = state_q.mux[idx];
         state_d.rdata[port_ctl_pkg::irq_cfg_lsb +: 4]      = state_q.cfg[idx];
         state_d.rdata[port_ctl_pkg::flag_bit]              = state_q.flag[idx];
      end else if (rd_in && (addr_in == port_ctl_pkg::isfr_offset)) begin
         state_d.rdata = state_q.flag;
      end
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_q <= reset_state;
      end else begin
         state_q <= state_d;
      end
   end

   // *****************************************************************
   // Outputs.
   // *****************************************************************
   assign rdata_out         = state_q.rdata;
   assign bus_err_out       = state_q.berr;
   assign pull_enable_out   = state_q.pe_out;
   assign pull_select_out   = state_q.ps_out;
   assign slew_slow_out     = state_q.sre;
   assign filter_enable_out = state_q.pfe;
   assign drive_high_out    = state_q.dse;
   assign open_drain_out    = state_q.od_out;
   assign mux_sel_out       = state_q.mux;
   assign irq_out           = state_q.irq;
   assign dma_req_out       = state_q.dma;

endmodule

`default_nettype wire
